// ### rtl/nv_host.sv
// Overview of operation
// (R01) read: chip select and output drive low, write strobe high
// (R02) fifteen address bits pick one of 32,768 bytes
// (R03) read data follows the address; sampled while selected
// (R04) data pins released while output drive high
// (R05) write: select and strobe low; data taken when either rises
// (R06) host holds address stable through the whole write
// (R07) host keeps output drive high during writes
// (R08) six ordered reads request a nonvolatile operation
// (R09) sixth read at save address starts a save
// (R10) sixth read at reload address starts a reload
// (R11) any other access between steps aborts the sequence
// (R12) host uses only reads with write strobe high for steps
// (R13) port disabled while a save runs
// (R14) port usable again after the save time
// (R15) reload clears then copies the array
// (R16) port usable again after the reload time
// (R17) supply rising starts an automatic reload
// (R18) host keeps strobes idle during power-up reload
// (R19) below threshold, saves and writes are not issued
// (R20) sequence addresses use only the lower 14 bits
// (R21) save wait is 10 ms
// (R22) power-up reload wait is 550 us
// (R23) a mismatch restarts; first address counts as step one
module nv_host (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // supply status pin
  input  wire logic                   supply_ok,
  // command side
  input  wire logic                   cmd_valid,
  input  nv_host_pkg::cmd_type        cmd,
  output logic                        cmd_ready,
  output logic                        rsp_valid,
  output logic [7:0]                  rsp_data,
  output logic                        busy,
  // memory pins
  output nv_host_pkg::pins_type       pins,
  output logic [7:0]                  data_pins_out,
  output logic                        data_pins_oe_n,
  input  wire logic [7:0]             data_pins_in
);
  typedef enum logic [2:0] {
    st_idle, st_rd, st_wr, st_seq, st_wait, st_gap
  } state_type;

  function automatic logic [13:0] seq_addr(input logic [2:0] idx,
                                           input logic       rel);
    case (idx)
      3'h0: seq_addr = nv_host_pkg::seq_a1;
      3'h1: seq_addr = nv_host_pkg::seq_a2;
      3'h2: seq_addr = nv_host_pkg::seq_a3;
      3'h3: seq_addr = nv_host_pkg::seq_a4;
      3'h4: seq_addr = nv_host_pkg::seq_a5;
      default: seq_addr = rel ? nv_host_pkg::seq_reload
                              : nv_host_pkg::seq_save;
    endcase
  endfunction : seq_addr

  localparam logic [19:0] store_cnt  = 20'(nv_host_pkg::store_cycles);
  localparam logic [19:0] reload_cnt = 20'(nv_host_pkg::reload_cycles);
  localparam logic [19:0] rd_cnt     = 20'(nv_host_pkg::rd_sync_cycles);

  logic                   ok_s1_r, ok_s2_r, ok_s3_r;
  logic [7:0]             din_s1_r, din_s2_r;
  state_type              state_r, state_nxt;
  nv_host_pkg::pins_type  pins_r, pins_nxt;
  logic [7:0]             dout_r, dout_nxt;
  logic                   doe_n_r, doe_n_nxt;
  logic [2:0]             step_r, step_nxt;
  logic                   rel_r, rel_nxt;
  logic [19:0]            cnt_r, cnt_nxt;
  logic                   rdy_r, rdy_nxt;
  logic                   rv_r, rv_nxt;
  logic [7:0]             rd_r, rd_nxt;
  logic                   busy_r, busy_nxt;
  logic                   pend_r, pend_nxt;

  always_comb begin
    state_nxt = state_r;
    pins_nxt  = pins_r;
    dout_nxt  = dout_r;
    doe_n_nxt = doe_n_r;
    step_nxt  = step_r;
    rel_nxt   = rel_r;
    cnt_nxt   = cnt_r;
    rdy_nxt   = 1'b0;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    busy_nxt  = busy_r;
    pend_nxt  = pend_r || (ok_s2_r && !ok_s3_r);              // (R17)
    case (state_r)
      st_idle: begin
        if (pend_r) begin
          pend_nxt  = 1'b0;
          cnt_nxt   = reload_cnt;                             // (R17) (R22)
          busy_nxt  = 1'b1;
          state_nxt = st_wait;                                // (R18)
        end else if (cmd_valid && rdy_r) begin
          pins_nxt.addr = cmd.addr;                           // (R02) (R06)
          busy_nxt = 1'b1;
          case (cmd.op)
            nv_host_pkg::op_read: begin
              pins_nxt.ce_n = 1'b0;                           // (R01)
              pins_nxt.oe_n = 1'b0;
              cnt_nxt   = rd_cnt;
              state_nxt = st_rd;
            end
            nv_host_pkg::op_write: begin
              if (ok_s2_r) begin                              // (R19)
                pins_nxt.ce_n = 1'b0;                         // (R05) (R07)
                pins_nxt.we_n = 1'b0;
                dout_nxt  = cmd.wdata;
                doe_n_nxt = 1'b0;
                state_nxt = st_wr;
              end else begin
                rv_nxt    = 1'b1;
                busy_nxt  = 1'b0;
                state_nxt = st_gap;
              end
            end
            default: begin
              rel_nxt  = (cmd.op == nv_host_pkg::op_reload);
              step_nxt = 3'h0;
              if (!ok_s2_r && cmd.op == nv_host_pkg::op_save) begin
                rv_nxt    = 1'b1;                             // (R19)
                busy_nxt  = 1'b0;
                state_nxt = st_gap;
              end else begin
                pins_nxt.addr = {1'b0, nv_host_pkg::seq_a1};  // (R08) (R20)
                pins_nxt.ce_n = 1'b0;                         // (R12)
                state_nxt = st_seq;
              end
            end
          endcase
        end
      end
      st_rd: begin
        if (cnt_r != 20'h0) begin
          cnt_nxt = cnt_r - 20'h1;
        end else begin
          rd_nxt        = din_s2_r;                           // (R03)
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;                               // (R04)
          rv_nxt        = 1'b1;
          busy_nxt      = 1'b0;
          state_nxt     = st_gap;
        end
      end
      st_wr: begin
        pins_nxt.ce_n = 1'b1;                                 // (R05)
        pins_nxt.we_n = 1'b1;
        rv_nxt        = 1'b1;
        busy_nxt      = 1'b0;
        state_nxt     = st_gap;
      end
      st_seq: begin
        pins_nxt.ce_n = 1'b1;                                 // (R11) (R23)
        if (step_r == nv_host_pkg::seq_steps - 3'h1) begin
          cnt_nxt   = rel_r ? reload_cnt : store_cnt;         // (R09) (R10)
          state_nxt = st_wait;                                // (R13) (R15)
        end else begin
          step_nxt  = step_r + 3'h1;
          state_nxt = st_gap;
        end
      end
      st_wait: begin
        if (cnt_r == 20'h0) begin
          rv_nxt    = 1'b1;                                   // (R14) (R16)
          busy_nxt  = 1'b0;
          state_nxt = st_gap;
        end else begin
          cnt_nxt = cnt_r - 20'h1;                            // (R21)
        end
      end
      st_gap: begin
        doe_n_nxt = 1'b1;
        if (busy_r) begin
          pins_nxt.addr = {1'b0, seq_addr(step_r, rel_r)};   // (R08) (R20)
          pins_nxt.ce_n = 1'b0;
          state_nxt     = st_seq;
        end else begin
          state_nxt = st_idle;
        end
      end
      default: state_nxt = st_idle;
    endcase
    rdy_nxt = (state_nxt == st_idle) && !pend_nxt;            // (R18)
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ok_s1_r  <= 1'b0;
      ok_s2_r  <= 1'b0;
      ok_s3_r  <= 1'b0;
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
      state_r  <= st_idle;
      pins_r   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000};
      dout_r   <= 8'h00;
      doe_n_r  <= 1'b1;
      step_r   <= 3'h0;
      rel_r    <= 1'b0;
      cnt_r    <= 20'h00000;
      rdy_r    <= 1'b0;
      rv_r     <= 1'b0;
      rd_r     <= 8'h00;
      busy_r   <= 1'b0;
      pend_r   <= 1'b0;
    end else if (clk_en) begin
      ok_s1_r  <= supply_ok;
      ok_s2_r  <= ok_s1_r;
      ok_s3_r  <= ok_s2_r;
      din_s1_r <= data_pins_in;
      din_s2_r <= din_s1_r;
      state_r  <= state_nxt;
      pins_r   <= pins_nxt;
      dout_r   <= dout_nxt;
      doe_n_r  <= doe_n_nxt;
      step_r   <= step_nxt;
      rel_r    <= rel_nxt;
      cnt_r    <= cnt_nxt;
      rdy_r    <= rdy_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      busy_r   <= busy_nxt;
      pend_r   <= pend_nxt;
    end
  end

  assign pins           = pins_r;
  assign data_pins_out  = dout_r;
  assign data_pins_oe_n = doe_n_r;
  assign cmd_ready      = rdy_r;
  assign rsp_valid      = rv_r;
  assign rsp_data       = rd_r;
  assign busy           = busy_r;

  sequence s_step_pulse;
    !pins_r.ce_n ##1 pins_r.ce_n;
  endsequence

  a_write_oe_high: assert property (@(posedge sys_clk) disable iff (rst)
    !pins_r.we_n |-> pins_r.oe_n && !doe_n_r)              // (R07)
    else $error("write with output drive low");
  a_read_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
    !pins_r.oe_n |-> doe_n_r && pins_r.we_n)               // (R04)
    else $error("host drives data during read");
  a_read_hold: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == st_rd |-> !pins_r.ce_n && !pins_r.oe_n)      // (R03)
    else $error("read strobes dropped early");
  a_pend_no_ready: assert property (@(posedge sys_clk) disable iff (rst)
    pend_r |-> !rdy_r)                                      // (R18)
    else $error("ready while power-up reload pending");
  a_seq_no_write: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == st_seq |-> pins_r.we_n && !pins_r.ce_n)     // (R12)
    else $error("sequence step not a read");
  a_seq_top_bit: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == st_seq |-> !pins_r.addr[14])                // (R20)
    else $error("sequence address top bit set");
  a_seq_first: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == st_seq && step_r == 3'h0 |->
      pins_r.addr[13:0] == nv_host_pkg::seq_a1)             // (R08)
    else $error("sequence starts at wrong address");
  a_seq_last: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == st_seq && step_r == 3'h5 |->
      pins_r.addr[13:0] == (rel_r ? nv_host_pkg::seq_reload
                                  : nv_host_pkg::seq_save))  // (R09) (R10)
    else $error("wrong final sequence address");
  a_wait_idle: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == st_wait |-> pins_r.ce_n && pins_r.we_n)     // (R13) (R18)
    else $error("port used during wait");
  a_seq_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && state_r == st_seq |-> s_step_pulse)         // (R11)
    else $error("sequence step not ended");
  a_no_low_write: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(pins_r.we_n) |-> $past(ok_s2_r))                 // (R19)
    else $error("write issued on low supply");
endmodule : nv_host

// ### rtl/nv_host_pkg.sv
package nv_host_pkg;
  localparam int unsigned  clk_mhz          = 10;
  localparam int unsigned  addr_w           = 15;
  localparam int unsigned  data_w           = 8;
  localparam int unsigned  mem_bytes        = 32768;
  localparam int unsigned  seq_cmp_w        = 14;
  localparam int unsigned  cyc_lo           = 1;
  localparam int unsigned  cyc_hi           = 1;
  localparam int unsigned  store_ms         = 10;
  localparam int unsigned  store_cycles     = store_ms * 1000 * clk_mhz;
  localparam int unsigned  reload_us        = 550;
  localparam int unsigned  reload_cycles    = reload_us * clk_mhz;
  localparam int unsigned  rd_sync_cycles   = 2;
  localparam logic [13:0]  seq_a1           = 14'h0e38;
  localparam logic [13:0]  seq_a2           = 14'h31c7;
  localparam logic [13:0]  seq_a3           = 14'h03e0;
  localparam logic [13:0]  seq_a4           = 14'h3c1f;
  localparam logic [13:0]  seq_a5           = 14'h303f;
  localparam logic [13:0]  seq_save         = 14'h0fc0;
  localparam logic [13:0]  seq_reload       = 14'h0c63;
  localparam logic [2:0]   seq_steps        = 3'h6;

  typedef enum logic [1:0] {
    op_read, op_write, op_save, op_reload
  } op_type;

  typedef struct packed {
    op_type      op;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } cmd_type;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [14:0] addr;
  } pins_type;
endpackage : nv_host_pkg

// ### sim/nv_dev_model.sv
module nv_dev_model #(
  parameter int save_ns   = 5000000,
  parameter int reload_ns = 400000
) (
  // supply and pins
  input  wire logic             supply_ok,
  input  nv_host_pkg::pins_type pins,
  // data pins
  input  wire logic [7:0]       dq_in,
  output logic                  dq_oe,
  output logic [7:0]            dq_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:32767];
  logic [7:0]  nv [0:32767];
  logic [13:0] seq [0:4];
  logic [13:0] a;
  logic        dis = 1'b0;
  int          step = 0;
  wire         wr_act = !pins.ce_n && !pins.we_n;

  initial begin
    seq = '{nv_host_pkg::seq_a1, nv_host_pkg::seq_a2, nv_host_pkg::seq_a3,
            nv_host_pkg::seq_a4, nv_host_pkg::seq_a5};
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'h00;
      nv[i] = i[7:0] ^ i[14:7] ^ 8'h5a;
    end
  end

  assign dq_oe = !pins.ce_n && !pins.oe_n && pins.we_n && !dis;
  assign dq_q = mem[pins.addr];

  task automatic do_reload;
    dis = 1'b1;
    for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
    for (int i = 0; i < 32768; i++) mem[i] = nv[i];
    #reload_ns;
    dis = 1'b0;
  endtask : do_reload

  task automatic do_save;
    dis = 1'b1;
    for (int i = 0; i < 32768; i++) nv[i] = mem[i];
    #save_ns;
    dis = 1'b0;
  endtask : do_save

  always @(negedge wr_act) begin
    if (!dis && supply_ok) mem[pins.addr] = dq_in;
  end
  always @(posedge wr_act) step = 0;
  always @(posedge supply_ok) do_reload();
  always @(negedge pins.ce_n) begin
    if (pins.we_n && !dis) begin
      a = pins.addr[13:0];
      if (step == 5 && a == nv_host_pkg::seq_save && supply_ok) begin
        step = 0;
        do_save();
      end else if (step == 5 && a == nv_host_pkg::seq_reload) begin
        step = 0;
        do_reload();
      end else if (step < 5 && a == seq[step]) begin
        step++;
      end else begin
        step = (a == seq[0]) ? 1 : 0;
      end
    end
  end
endmodule : nv_dev_model

// ### sim/nonvolatile_sram_sequencer_bench.sv
module nonvolatile_sram_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] rd_lat = 8'(nv_host_pkg::rd_sync_cycles + 2);
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 clk_en = 1'b1;
  logic                 supply_ok = 1'b0;
  logic                 cmd_valid = 1'b0;
  nv_host_pkg::cmd_type cmd = '0;
  nv_host_pkg::pins_type pins;
  logic                 cmd_ready, rsp_valid, busy, data_pins_oe_n, dev_oe;
  logic [7:0]           rsp_data, data_pins_out, dev_q, dq_w, rd, d;
  logic [7:0]           dq_last = 8'h00;
  logic [14:0]          a, k0;
  logic [7:0]           sb [logic [14:0]];
  int                   n_fail = 0, compares = 0, seed = 92, lat;

  always #50 sys_clk = ~sys_clk;
  always_comb dq_w = !data_pins_oe_n ? data_pins_out : dev_oe ? dev_q : ~dq_last;
  always @(posedge sys_clk) dq_last <= dq_w;

  nv_host nv_host_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .supply_ok(supply_ok), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy), .pins(pins), .data_pins_out(data_pins_out),
    .data_pins_oe_n(data_pins_oe_n), .data_pins_in(dq_w));
  nv_dev_model nv_dev_model_i (.supply_ok(supply_ok), .pins(pins),
    .dq_in(dq_w), .dq_oe(dev_oe), .dq_q(dev_q));

  function automatic logic [7:0] nv_pat(input logic [14:0] x);
    return x[7:0] ^ x[14:7] ^ 8'h5a;
  endfunction : nv_pat

  function automatic logic [7:0] expect_at(input logic [14:0] x);
    return sb.exists(x) ? sb[x] : nv_pat(x);
  endfunction : expect_at

  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic op(input nv_host_pkg::op_type o, input logic [14:0] x,
                    input logic [7:0] wd, input int bound);
    int k;
    cmd_valid <= 1'b1;
    cmd <= '{o, x, wd};
    for (k = 0; k < 7000; k++) begin
      @(posedge sys_clk);
      if (cmd_ready === 1'b1) break;
    end
    cmd_valid <= 1'b0;
    for (lat = 1; lat < bound; lat++) begin
      @(posedge sys_clk);
      if (rsp_valid === 1'b1) break;
    end
    if (k >= 7000 || lat >= bound) begin
      check("handshake", 8'h00, 8'h01);
      conclude();
    end else begin
      rd = rsp_data;
    end
  endtask : op

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    op(nv_host_pkg::op_write, 15'h0123, 8'ha5, 10);
    op(nv_host_pkg::op_read, 15'h0123, 8'h00, 10);
    check("inhibited write", rd, 8'h00);
    op(nv_host_pkg::op_save, 15'h0000, 8'h00, 10);
    check("inhibited save latency", lat[7:0], 8'h01);
    $display("test inhibit done");
    supply_ok <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("power-up busy", {7'h00, busy}, 8'h01);
    op(nv_host_pkg::op_read, 15'h0123, 8'h00, 10);
    check("power-up reload", rd, nv_pat(15'h0123));
    $display("test power-up done");
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7fff : 15'($random(seed));
      d = 8'($random(seed));
      op(nv_host_pkg::op_write, a, d, 10);
      sb[a] = d;
      op(nv_host_pkg::op_read, a ^ 15'h4000, 8'h00, 10);
      check("read other half", rd, expect_at(a ^ 15'h4000));
      fork
        op(nv_host_pkg::op_read, a, 8'h00, 10);
        if (i == 2) begin
          @(posedge sys_clk);
          clk_en <= 1'b0;
          repeat (3) @(posedge sys_clk);
          clk_en <= 1'b1;
        end
      join
      check("read back", rd, d);
      check("latency", lat[7:0], (i == 2) ? rd_lat + 8'h03 : rd_lat);
    end
    $display("test random traffic done");
    void'(sb.first(k0));
    op(nv_host_pkg::op_write, 15'h0042, 8'h3c, 10);
    op(nv_host_pkg::op_save, 15'h0000, 8'h00, 100100);
    op(nv_host_pkg::op_write, 15'h0042, 8'hc3, 10);
    op(nv_host_pkg::op_read, 15'h0042, 8'h00, 10);
    check("write after save", rd, 8'hc3);
    for (int r = 0; r < 2; r++) begin
      op(nv_host_pkg::op_reload, 15'h0000, 8'h00, 6000);
      op(nv_host_pkg::op_read, 15'h0042, 8'h00, 10);
      check("reloaded byte", rd, 8'h3c);
      op(nv_host_pkg::op_read, k0, 8'h00, 10);
      check("reloaded other", rd, sb[k0]);
    end
    $display("test save and reload done");
    conclude();
  end
endmodule : nonvolatile_sram_sequencer_bench
